// file: rtl/rcc_pkg.sv
package rcc_pkg;

   localparam logic [7:0] RCC_MAIN_OFS = 8'h11;
   localparam logic [7:0] RCC_LIMLO_OFS = 8'h12;
   localparam logic [7:0] RCC_SCALE_OFS = 8'h13;
   localparam logic [7:0] RCC_INVR_OFS = 8'h14;
   localparam logic [7:0] RCC_BEMF_OFS = 8'h15;

   localparam logic [7:0] RCC_MAIN_RST = 8'h88;
   localparam logic [7:0] RCC_LIMLO_RST = 8'hFF;
   localparam logic [7:0] RCC_SCALE_RST = 8'h7F;
   localparam logic [7:0] RCC_INVR_RST = 8'h00;
   localparam logic [7:0] RCC_BEMF_RST = 8'h00;

   localparam int RCC_EN_BIT = 7;
   localparam int RCC_ECDIS_BIT = 6;
   localparam int RCC_FLOAT_BIT = 5;
   localparam int RCC_FGAIN_LSB = 3;
   localparam int RCC_CGAIN_LSB = 0;
   localparam int RCC_INVRM_LSB = 6;
   localparam int RCC_BEMFM_LSB = 4;
   localparam int RCC_LIMM_LSB = 2;
   localparam int RCC_LIMHI_LSB = 0;

   localparam int RCC_TALLY_W = 16;

   typedef struct packed {
      logic ripple_count_enable;
      logic error_correct_disable;
      logic bridge_float_on_limit;
      logic [4:0] filter_input_gain;
      logic [1:0] current_scale;
      logic [13:0] inverse_resistance_multiplier;
      logic [17:0] backemf_constant_multiplier;
      logic [7:0] inverse_resistance;
      logic [7:0] backemf_constant;
   } rcc_cfg_type;

   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rcc_req_type;
endpackage : rcc_pkg

// file: rtl/rcc_limit_cmp.sv
`timescale 1ns/1ps
module rcc_limit_cmp (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic [9:0] limit_i,
   input wire logic [1:0] mult_sel_i,
   input wire logic [rcc_pkg::RCC_TALLY_W-1:0] tally_i,
   input wire logic active_i,
   output logic over_o
);
   import rcc_pkg::*;

   typedef struct packed {
      logic [15:0] eff;
      logic over;
   } rcc_cmp_type;

   rcc_cmp_type st_reg;
   rcc_cmp_type st_next;

   function automatic logic [15:0] scale_limit(input logic [9:0] v,
                                                input logic [1:0] s);
      case (s)
         2'h0: scale_limit = {5'h00, v, 1'h0};
         2'h1: scale_limit = {3'h0, v, 3'h0};
         2'h2: scale_limit = {2'h0, v, 4'h0};
         default: scale_limit = {v, 6'h00};
      endcase
   endfunction : scale_limit

   always_comb begin
      st_next = st_reg;
      st_next.eff = scale_limit(limit_i, mult_sel_i);
      st_next.over = active_i && (tally_i > st_reg.eff);
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign over_o = st_reg.over;

   AST_OVER_NEEDS_ACTIVE: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) over_o |-> $past(active_i))
      else $error("limit flag set while counting off");
endmodule : rcc_limit_cmp

// file: rtl/rcc_config_bank.sv
`timescale 1ns/1ps
module rcc_config_bank (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire rcc_pkg::rcc_req_type req_i,
   input wire logic [rcc_pkg::RCC_TALLY_W-1:0] ripple_tally_i,
   output logic [7:0] rdata_o,
   output rcc_pkg::rcc_cfg_type cfg_o,
   output logic limit_over_o,
   output logic bridge_hiz_o
);
   import rcc_pkg::*;

   typedef struct packed {
      logic [7:0] main_ctl;
      logic [7:0] lim_lo;
      logic [7:0] scale_sel;
      logic [7:0] invr;
      logic [7:0] bemf;
      logic [9:0] lim_shadow;
      logic [7:0] rdata;
      rcc_cfg_type cfg;
      logic hiz;
   } rcc_state_type;

   rcc_state_type st_reg;
   rcc_state_type st_next;
   logic over;

   function automatic logic [13:0] invr_mult(input logic [1:0] s);
      case (s)
         2'h0: invr_mult = 14'h0002;
         2'h1: invr_mult = 14'h0040;
         2'h2: invr_mult = 14'h0400;
         default: invr_mult = 14'h2000;
      endcase
   endfunction : invr_mult

   // 24 * 2^n built as 3 << (n+3)
   // the largest value needs 18 bits
   function automatic logic [17:0] bemf_mult(input logic [1:0] s);
      case (s)
         2'h0: bemf_mult = 18'h01800;
         2'h1: bemf_mult = 18'h03000;
         2'h2: bemf_mult = 18'h18000;
         default: bemf_mult = 18'h30000;
      endcase
   endfunction : bemf_mult

   always_comb begin
      st_next = st_reg;
      if (req_i.wr) begin
         case (req_i.addr)
            RCC_MAIN_OFS: st_next.main_ctl = req_i.wdata;
            RCC_LIMLO_OFS: st_next.lim_lo = req_i.wdata;
            RCC_SCALE_OFS: st_next.scale_sel = req_i.wdata;
            RCC_INVR_OFS: st_next.invr = req_i.wdata;
            RCC_BEMF_OFS: st_next.bemf = req_i.wdata;
            default: ;
         endcase
      end
      // both halves copied together every cycle, so after a write to one half the compare sees it with the other half's old value
      st_next.lim_shadow = {st_reg.scale_sel[RCC_LIMHI_LSB +: 2],
                            st_reg.lim_lo};
      case (req_i.addr)
         RCC_MAIN_OFS: st_next.rdata = st_reg.main_ctl;
         RCC_LIMLO_OFS: st_next.rdata = st_reg.lim_lo;
         RCC_SCALE_OFS: st_next.rdata = st_reg.scale_sel;
         RCC_INVR_OFS: st_next.rdata = st_reg.invr;
         RCC_BEMF_OFS: st_next.rdata = st_reg.bemf;
         default: st_next.rdata = 8'h00;
      endcase
      st_next.cfg.ripple_count_enable = st_reg.main_ctl[RCC_EN_BIT];
      st_next.cfg.error_correct_disable =
         st_reg.main_ctl[RCC_ECDIS_BIT];
      st_next.cfg.bridge_float_on_limit =
         st_reg.main_ctl[RCC_FLOAT_BIT];
      st_next.cfg.filter_input_gain =
         5'h02 << st_reg.main_ctl[RCC_FGAIN_LSB +: 2];
      // both bits of the current select pass to current_scale unchanged
      st_next.cfg.current_scale =
         st_reg.main_ctl[RCC_CGAIN_LSB +: 2];
      st_next.cfg.inverse_resistance_multiplier =
         invr_mult(st_reg.scale_sel[RCC_INVRM_LSB +: 2]);
      st_next.cfg.backemf_constant_multiplier =
         bemf_mult(st_reg.scale_sel[RCC_BEMFM_LSB +: 2]);
      st_next.cfg.inverse_resistance = st_reg.invr;
      st_next.cfg.backemf_constant = st_reg.bemf;
      // float only while enabled; clearing the bit re-enables the bridge
      st_next.hiz = over && st_reg.main_ctl[RCC_FLOAT_BIT];
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg <= '0;
         st_reg.main_ctl <= RCC_MAIN_RST;
         st_reg.lim_lo <= RCC_LIMLO_RST;
         st_reg.scale_sel <= RCC_SCALE_RST;
         st_reg.invr <= RCC_INVR_RST;
         st_reg.bemf <= RCC_BEMF_RST;
         st_reg.lim_shadow <= {RCC_SCALE_RST[RCC_LIMHI_LSB +: 2],
                               RCC_LIMLO_RST};
      end else begin
         st_reg <= st_next;
      end
   end

   rcc_limit_cmp u_cmp (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .limit_i(st_reg.lim_shadow),
      .mult_sel_i(st_reg.scale_sel[RCC_LIMM_LSB +: 2]),
      .tally_i(ripple_tally_i),
      .active_i(st_reg.main_ctl[RCC_EN_BIT]),
      .over_o(over)
   );

   assign rdata_o = st_reg.rdata;
   assign cfg_o = st_reg.cfg;
   assign limit_over_o = over;
   assign bridge_hiz_o = st_reg.hiz;

   sequence s_main_write;
      req_i.wr && req_i.addr == RCC_MAIN_OFS;
   endsequence

   sequence s_limlo_write;
      req_i.wr && req_i.addr == RCC_LIMLO_OFS;
   endsequence

   sequence s_scale_write;
      req_i.wr && req_i.addr == RCC_SCALE_OFS;
   endsequence

   // cfg and rdata hold zeros through the release edge, so checks that
   // compare them with register contents of nonzero reset value wait for one clean edge
   AST_EN_FOLLOWS: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) s_main_write |-> ##2
      cfg_o.ripple_count_enable == $past(req_i.wdata[RCC_EN_BIT], 2))
      else $error("enable did not follow write");
   AST_ECDIS_FOLLOWS: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) s_main_write |-> ##2
      cfg_o.error_correct_disable == $past(req_i.wdata[RCC_ECDIS_BIT], 2))
      else $error("correction disable did not follow write");
   AST_FLOAT_FOLLOWS: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) s_main_write |-> ##2
      cfg_o.bridge_float_on_limit == $past(req_i.wdata[RCC_FLOAT_BIT], 2))
      else $error("float bit did not follow write");
   AST_HIZ_CAUSE: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) bridge_hiz_o |->
      $past(limit_over_o) && $past(st_reg.main_ctl[RCC_FLOAT_BIT]))
      else $error("bridge floated without cause");
   AST_HIZ_SET: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) limit_over_o && st_reg.main_ctl[RCC_FLOAT_BIT]
      |=> bridge_hiz_o)
      else $error("bridge not floated past limit");
   AST_FGAIN: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) $past(rst_n_i) |-> cfg_o.filter_input_gain ==
      (5'h02 << $past(st_reg.main_ctl[RCC_FGAIN_LSB +: 2])))
      else $error("filter gain wrong");
   AST_CSCALE: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) cfg_o.current_scale ==
      $past(st_reg.main_ctl[RCC_CGAIN_LSB +: 2]))
      else $error("current scale wrong");
   AST_INVR_MULT0: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) $past(rst_n_i) &&
      $past(st_reg.scale_sel[RCC_INVRM_LSB +: 2]) == 2'h0 |->
      cfg_o.inverse_resistance_multiplier == 14'h0002)
      else $error("inverse resistance multiplier wrong");
   AST_INVR_MULT1: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) $past(rst_n_i) &&
      $past(st_reg.scale_sel[RCC_INVRM_LSB +: 2]) == 2'h1 |->
      cfg_o.inverse_resistance_multiplier == 14'h0040)
      else $error("inverse resistance multiplier wrong");
   AST_INVR_MULT2: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) $past(rst_n_i) &&
      $past(st_reg.scale_sel[RCC_INVRM_LSB +: 2]) == 2'h2 |->
      cfg_o.inverse_resistance_multiplier == 14'h0400)
      else $error("inverse resistance multiplier wrong");
   AST_INVR_MULT: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) $past(rst_n_i) &&
      $past(st_reg.scale_sel[RCC_INVRM_LSB +: 2]) == 2'h3 |->
      cfg_o.inverse_resistance_multiplier == 14'h2000)
      else $error("inverse resistance multiplier wrong");
   AST_BEMF_MULT: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) $past(rst_n_i) &&
      $past(st_reg.scale_sel[RCC_BEMFM_LSB +: 2]) == 2'h0 |->
      cfg_o.backemf_constant_multiplier == 18'h01800)
      else $error("back-EMF multiplier wrong");
   AST_BEMF_MULT1: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) $past(rst_n_i) &&
      $past(st_reg.scale_sel[RCC_BEMFM_LSB +: 2]) == 2'h1 |->
      cfg_o.backemf_constant_multiplier == 18'h03000)
      else $error("back-EMF multiplier wrong");
   AST_BEMF_MULT2: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) $past(rst_n_i) &&
      $past(st_reg.scale_sel[RCC_BEMFM_LSB +: 2]) == 2'h2 |->
      cfg_o.backemf_constant_multiplier == 18'h18000)
      else $error("back-EMF multiplier wrong");
   AST_BEMF_MULT3: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) $past(rst_n_i) &&
      $past(st_reg.scale_sel[RCC_BEMFM_LSB +: 2]) == 2'h3 |->
      cfg_o.backemf_constant_multiplier == 18'h30000)
      else $error("back-EMF multiplier wrong");
   AST_BEMF_READ: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) $past(rst_n_i) && !req_i.wr &&
      req_i.addr == RCC_BEMF_OFS |=> rdata_o == $past(st_reg.bemf))
      else $error("back-EMF readback wrong");
   AST_LIMLO_READ: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) $past(rst_n_i) && !req_i.wr &&
      req_i.addr == RCC_LIMLO_OFS |=> rdata_o == $past(st_reg.lim_lo))
      else $error("limit low readback wrong");
   AST_SCALE_READ: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) $past(rst_n_i) && !req_i.wr &&
      req_i.addr == RCC_SCALE_OFS |=> rdata_o == $past(st_reg.scale_sel))
      else $error("scaling select readback wrong");
   AST_UNMAPPED_READ: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) req_i.addr < RCC_MAIN_OFS ||
      req_i.addr > RCC_BEMF_OFS |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   AST_INVR_VALUE: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) cfg_o.inverse_resistance ==
      $past(st_reg.invr))
      else $error("inverse resistance value wrong");
   AST_BEMF_VALUE: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) cfg_o.backemf_constant ==
      $past(st_reg.bemf))
      else $error("back-EMF constant value wrong");
   AST_LIMLO_TAKEN: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) s_limlo_write |-> ##2
      st_reg.lim_shadow[7:0] == $past(req_i.wdata, 2))
      else $error("limit low byte not taken");
   AST_LIMHI_TAKEN: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) s_scale_write |-> ##2
      st_reg.lim_shadow[9:8] == $past(req_i.wdata[RCC_LIMHI_LSB +: 2], 2))
      else $error("limit top bits not taken");
   AST_LIMIT_WHOLE: assert property (@(posedge core_clk_i)
      disable iff (!rst_n_i) st_reg.lim_shadow ==
      {$past(st_reg.scale_sel[1:0]), $past(st_reg.lim_lo)})
      else $error("limit halves mixed");
endmodule : rcc_config_bank

// file: dv/rcc_host_model.sv
`timescale 1ns/1ps
module rcc_host_model (
   input wire logic core_clk_i,
   input wire logic [7:0] rdata_i,
   output rcc_pkg::rcc_req_type req_o
);
   import rcc_pkg::*;
   // the regulation select is outside; counting stays on unless a
   // scenario turns it off on purpose
   initial req_o = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      // a zero here would stall the ripple math downstream
      if (a == RCC_INVR_OFS && d == 8'h00) d = 8'h01;
      @(posedge core_clk_i);
      req_o <= '{1'b1, a, d};
      @(posedge core_clk_i);
      req_o.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk_i);
      req_o.addr <= a;
      @(posedge core_clk_i);
      #1;
      d = rdata_i;
   endtask : rd
endmodule : rcc_host_model

// file: dv/ripple_count_config_bank_tb.sv
`timescale 1ns/1ps
module ripple_count_config_bank_tb;
   import rcc_pkg::*;
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [RCC_TALLY_W-1:0] tally = '0;
   rcc_req_type req;
   logic [7:0] rdata;
   rcc_cfg_type cfg;
   logic over;
   logic hiz;
   int error_cnt = 0;
   int samples_checked = 0;
   int lm[4] = '{2, 8, 16, 64};
   int im[4] = '{2, 64, 1024, 8192};
   int bs[4] = '{8, 9, 12, 13};
   always #2.5 core_clk_i = ~core_clk_i;
   rcc_config_bank i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .req_i(req), .ripple_tally_i(tally), .rdata_o(rdata), .cfg_o(cfg),
      .limit_over_o(over), .bridge_hiz_o(hiz));
   rcc_host_model i_host (.core_clk_i(core_clk_i), .rdata_i(rdata),
      .req_o(req));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : wt
   task automatic st(input logic [RCC_TALLY_W-1:0] v);
      @(posedge core_clk_i);
      tally <= v;
   endtask : st
   task automatic t_reset();
      logic [7:0] d;
      logic [7:0] rv[5] = '{8'h88, 8'hFF, 8'h7F, 8'h00, 8'h00};
      chk(cfg.ripple_count_enable, 1'h1);
      chk(cfg.error_correct_disable, 1'h0);
      chk(cfg.bridge_float_on_limit, 1'h0);
      chk(cfg.filter_input_gain, 5'h04);
      chk(cfg.current_scale, 2'h0);
      chk(cfg.inverse_resistance_multiplier, 14'h0040);
      chk(cfg.backemf_constant_multiplier, 32'h0003_0000);
      chk(cfg.inverse_resistance, 8'h00);
      chk(cfg.backemf_constant, 8'h00);
      chk(over, 1'h0);
      chk(hiz, 1'h0);
      for (int i = 0; i < 5; i++) begin
         i_host.rd(RCC_MAIN_OFS + 8'(i), d);
         chk(d, rv[i]);
      end
   endtask : t_reset
   task automatic t_regs();
      logic [7:0] d;
      logic [7:0] a;
      // both ends of the window are unmapped and must read zero
      for (int i = 0; i < 7; i++) begin
         a = 8'h10 + 8'(i);
         i_host.wr(a, a ^ 8'hA5);
         i_host.rd(a, d);
         chk(d, (i == 0 || i == 6) ? 8'h00 : a ^ 8'hA5);
      end
      chk(cfg.inverse_resistance, 8'hB1);
      chk(cfg.backemf_constant, 8'hB0);
   endtask : t_regs
   task automatic t_codes();
      for (int c = 0; c < 4; c++) begin
         logic [1:0] k;
         k = c[1:0];
         i_host.wr(RCC_SCALE_OFS, {k, k, k, 2'b00});
         i_host.wr(RCC_MAIN_OFS, {3'b101, k, 1'b1, k});
         i_host.wr(RCC_LIMLO_OFS, 8'h05);
         st(16'(5 * lm[c]));
         #1;
         chk(cfg.bridge_float_on_limit, 1'h1);
         chk(cfg.filter_input_gain, 5'h02 << c);
         chk(cfg.current_scale, k);
         chk(cfg.inverse_resistance_multiplier, im[c]);
         chk(cfg.backemf_constant_multiplier, 32'h18 << bs[c]);
         wt(6);
         chk(over, 1'h0);
         st(16'(5 * lm[c] + 1));
         wt(3);
         chk(over, 1'h1);
         wt(1);
         chk(hiz, 1'h1);
      end
   endtask : t_codes
   task automatic t_gate();
      i_host.wr(RCC_MAIN_OFS, 8'h20);
      wt(6);
      chk(over, 1'h0);
      chk(hiz, 1'h0);
      i_host.wr(RCC_MAIN_OFS, 8'hC0);
      wt(6);
      chk(cfg.error_correct_disable, 1'h1);
      chk(cfg.bridge_float_on_limit, 1'h0);
      chk(over, 1'h1);
      chk(hiz, 1'h0);
      i_host.wr(RCC_SCALE_OFS, 8'h0F);
      i_host.wr(RCC_LIMLO_OFS, 8'hFF);
      st(16'hFFC0);
      wt(6);
      chk(over, 1'h0);
      st(16'hFFC1);
      wt(3);
      chk(over, 1'h1);
   endtask : t_gate
   // tally is parked first so the limit flag is clear after the reset
   task automatic t_midreset();
      st(16'h0000);
      @(posedge core_clk_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      wt(1);
      t_reset();
   endtask : t_midreset
   task automatic test_done();
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (5) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      wt(1);
      t_reset();
      t_regs();
      t_codes();
      t_gate();
      t_midreset();
      test_done();
   end
   // the whole sequence needs well under 1000 cycles
   initial begin
      #50000;
      error_cnt++;
      test_done();
   end
endmodule : ripple_count_config_bank_tb
